// File: common/chov_map.svh
`ifndef CHOV_MAP_SVH
`define CHOV_MAP_SVH

// Register offsets on the register port
`define CHOV_OFS_LF_OVER_THR 8'h93
`define CHOV_OFS_HF_FLT 8'h94

// Reset values
`define CHOV_RST_LF_OVER_THR 8'hFF
`define CHOV_RST_HF_FLT 8'h00

// Debounce filter field positions
`define CHOV_OVER_DEB_MSB 7
`define CHOV_OVER_DEB_LSB 4
`define CHOV_UNDER_DEB_MSB 3
`define CHOV_UNDER_DEB_LSB 0

// Threshold scaling, in millivolts
`define CHOV_X1_BASE_MV 13'h00C8
`define CHOV_X1_STEP_MV 13'h0005
`define CHOV_X4_BASE_MV 13'h0320
`define CHOV_X4_STEP_MV 13'h0014

// Debounce timing
`define CHOV_CLK_PERIOD_NS 50
`define CHOV_DEB_BASE_NS 100
`define CHOV_DEB_MAX_NS 102400
`define CHOV_DEB_LAST_DOUBLING 4'h9
`define CHOV_DEB_BASE_CYC ((`CHOV_DEB_BASE_NS + `CHOV_CLK_PERIOD_NS - 1) / `CHOV_CLK_PERIOD_NS)
`define CHOV_DEB_MAX_CYC (`CHOV_DEB_MAX_NS / `CHOV_CLK_PERIOD_NS)

`endif

// File: common/chov_pkg.sv
package chov_pkg;
    typedef logic [7:0] chov_code_t;
    typedef logic [3:0] chov_deb_sel_t;
    typedef logic [12:0] chov_mv_t;
    typedef logic [11:0] chov_cyc_t;
endpackage : chov_pkg

// File: core/chov_ch8_regbank.sv
`timescale 1ns/1ns
`include "chov_map.svh"

module chov_ch8_regbank
    import chov_pkg::*;
(
    input wire logic i_clock, // 20 MHz system clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_reg_wr, // Register write strobe
    input wire logic i_reg_rd, // Register read strobe
    input wire logic [7:0] i_reg_addr, // Register offset
    input wire logic [7:0] i_reg_wdata, // Write data
    output logic [7:0] o_reg_rdata, // Read data, registered
    input wire logic i_range_scale_select, // 0 = unity, 1 = fourfold
    input wire logic [12:0] i_lf_volt_mv, // Filtered channel voltage, mV
    input wire logic i_hf_over_cmp, // Raw HF overvoltage comparator
    input wire logic i_hf_under_cmp, // Raw HF undervoltage comparator
    output logic o_lf_over_fault, // LF overvoltage fault
    output logic o_hf_over_fault, // Debounced HF overvoltage fault
    output logic o_hf_under_fault // Debounced HF undervoltage fault
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Threshold code to millivolts for the selected range
    function automatic chov_mv_t thr_mv(input chov_code_t code, input logic x4);
        chov_mv_t c;
        c = {5'h00, code};
        if (x4) begin
            thr_mv = 13'(`CHOV_X4_BASE_MV + c * `CHOV_X4_STEP_MV);
        end else begin
            thr_mv = 13'(`CHOV_X1_BASE_MV + c * `CHOV_X1_STEP_MV);
        end
    endfunction : thr_mv

    // Debounce code to clock cycles; the top codes saturate
    function automatic chov_cyc_t deb_cycles(input chov_deb_sel_t sel);
        if (sel > `CHOV_DEB_LAST_DOUBLING) begin
            deb_cycles = 12'(`CHOV_DEB_MAX_CYC);
        end else begin
            deb_cycles = 12'(12'(`CHOV_DEB_BASE_CYC) << sel);
        end
    endfunction : deb_cycles

    // Reference table, halving down from the longest setting
    function automatic chov_cyc_t ref_deb_cycles(input chov_deb_sel_t sel);
        case (sel)
            4'h0: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 10);
            4'h1: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 9);
            4'h2: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 8);
            4'h3: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 7);
            4'h4: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 6);
            4'h5: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 5);
            4'h6: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 4);
            4'h7: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 3);
            4'h8: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 2);
            4'h9: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC >> 1);
            default: ref_deb_cycles = 12'(`CHOV_DEB_MAX_CYC);
        endcase
    endfunction : ref_deb_cycles

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    chov_code_t lowfreq_over_threshold_ff;
    logic [7:0] highfreq_fault_filter_ff;
    chov_deb_sel_t over_debounce_sel;
    chov_deb_sel_t under_debounce_sel;
    logic wr_thr;
    logic wr_flt;

    assign wr_thr = i_reg_wr && (i_reg_addr == `CHOV_OFS_LF_OVER_THR);
    assign wr_flt = i_reg_wr && (i_reg_addr == `CHOV_OFS_HF_FLT);
    assign over_debounce_sel = highfreq_fault_filter_ff[`CHOV_OVER_DEB_MSB:`CHOV_OVER_DEB_LSB];
    assign under_debounce_sel =
        highfreq_fault_filter_ff[`CHOV_UNDER_DEB_MSB:`CHOV_UNDER_DEB_LSB];

    // Threshold register, all ones so it starts at the highest limit of either range
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lowfreq_over_threshold_ff <= `CHOV_RST_LF_OVER_THR;
        end else if (wr_thr) begin
            lowfreq_over_threshold_ff <= i_reg_wdata;
        end
    end

    // Debounce filter register; saturating codes are accepted as written
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            highfreq_fault_filter_ff <= `CHOV_RST_HF_FLT;
        end else if (wr_flt) begin
            highfreq_fault_filter_ff <= i_reg_wdata;
        end
    end

    // Read data; unmapped offsets read zero
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `CHOV_OFS_LF_OVER_THR: o_reg_rdata <= lowfreq_over_threshold_ff;
                `CHOV_OFS_HF_FLT: o_reg_rdata <= highfreq_fault_filter_ff;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Low-frequency overvoltage compare

    chov_mv_t lf_limit_mv;

    assign lf_limit_mv = thr_mv(lowfreq_over_threshold_ff, i_range_scale_select);

    // Strict compare: sitting exactly on the threshold is not a fault
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_lf_over_fault <= 1'b0;
        end else begin
            o_lf_over_fault <= (i_lf_volt_mv > lf_limit_mv);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // High-frequency debounce

    chov_cyc_t ov_cnt_ff;
    chov_cyc_t uv_cnt_ff;
    chov_cyc_t ov_limit;
    chov_cyc_t uv_limit;

    assign ov_limit = deb_cycles(over_debounce_sel);
    assign uv_limit = deb_cycles(under_debounce_sel);

    // Overvoltage: output moves only after limit cycles of a steady new level
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ov_cnt_ff <= 12'h000;
            o_hf_over_fault <= 1'b0;
        end else if (i_hf_over_cmp == o_hf_over_fault) begin
            ov_cnt_ff <= 12'h000;
        end else if (ov_cnt_ff >= ov_limit - 12'h001) begin
            ov_cnt_ff <= 12'h000;
            o_hf_over_fault <= i_hf_over_cmp;
        end else begin
            ov_cnt_ff <= ov_cnt_ff + 12'h001;
        end
    end

    // Undervoltage: same filter; >= guards a limit shortened mid-count
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            uv_cnt_ff <= 12'h000;
            o_hf_under_fault <= 1'b0;
        end else if (i_hf_under_cmp == o_hf_under_fault) begin
            uv_cnt_ff <= 12'h000;
        end else if (uv_cnt_ff >= uv_limit - 12'h001) begin
            uv_cnt_ff <= 12'h000;
            o_hf_under_fault <= i_hf_under_cmp;
        end else begin
            uv_cnt_ff <= uv_cnt_ff + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    // Set once any register is written, so reset values can be checked
    logic touched_ff;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            touched_ff <= 1'b0;
        end else if (wr_thr || wr_flt) begin
            touched_ff <= 1'b1;
        end
    end

    a_thr_reset_value: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !touched_ff |-> lowfreq_over_threshold_ff == 8'hFF)
        else $error("threshold not at reset value");

    a_thr_write_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        wr_thr |=> (lowfreq_over_threshold_ff == $past(i_reg_wdata)) ##1
        ($past(wr_thr) || $stable(lowfreq_over_threshold_ff)))
        else $error("threshold write or hold wrong");

    a_flt_reset_value: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !touched_ff |-> highfreq_fault_filter_ff == 8'h00)
        else $error("filter not at reset value");

    a_x1_top_edge: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (!i_range_scale_select && lowfreq_over_threshold_ff == 8'hFF && !wr_thr)
        |=> o_lf_over_fault == ($past(i_lf_volt_mv) > 13'd1475))
        else $error("unity scale top threshold wrong");

    a_x4_low_edge: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_range_scale_select && lowfreq_over_threshold_ff == 8'h01)
        |=> o_lf_over_fault == ($past(i_lf_volt_mv) > 13'd820))
        else $error("fourfold scale step wrong");

    a_lf_fault_cause: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $rose(o_lf_over_fault) |-> $past(i_lf_volt_mv) > $past(lf_limit_mv))
        else $error("lf fault without cause");

    a_over_debounce_sel_short: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (over_debounce_sel == 4'h0 && !wr_flt && !o_hf_over_fault && i_hf_over_cmp)
        ##1 i_hf_over_cmp |=> o_hf_over_fault)
        else $error("ov debounce of two cycles missed");

    a_over_debounce_sel_early: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $rose(o_hf_over_fault) |-> $past(ov_cnt_ff) >= $past(ov_limit) - 12'h001)
        else $error("ov fault asserted before debounce time");

    a_under_debounce_sel_early: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $changed(o_hf_under_fault) |-> $past(uv_cnt_ff) >= $past(uv_limit) - 12'h001)
        else $error("uv fault moved before debounce time");

    a_deb_doubling: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        over_debounce_sel == 4'h9 |-> ov_limit == 12'd1024)
        else $error("doubling code cycles wrong");

    a_deb_saturate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        under_debounce_sel >= 4'hA |-> uv_limit == 12'd2048)
        else $error("saturated code cycles wrong");

    // Reference run lengths, kept apart from the filter counters
    chov_cyc_t ov_run_ff;
    chov_cyc_t uv_run_ff;
    logic ov_seen_ff;
    logic uv_seen_ff;
    chov_cyc_t ov_ref_lim;
    chov_cyc_t uv_ref_lim;

    assign ov_ref_lim = ref_deb_cycles(over_debounce_sel);
    assign uv_ref_lim = ref_deb_cycles(under_debounce_sel);

    // A fresh output level is timed afresh, just as the filter restarts
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ov_seen_ff <= 1'b0;
            ov_run_ff <= 12'h000;
        end else begin
            ov_seen_ff <= o_hf_over_fault;
            if (i_hf_over_cmp == o_hf_over_fault) begin
                ov_run_ff <= 12'h000;
            end else if (o_hf_over_fault != ov_seen_ff) begin
                ov_run_ff <= 12'h001;
            end else begin
                ov_run_ff <= ov_run_ff + 12'h001;
            end
        end
    end

    // Same reference for the undervoltage path
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            uv_seen_ff <= 1'b0;
            uv_run_ff <= 12'h000;
        end else begin
            uv_seen_ff <= o_hf_under_fault;
            if (i_hf_under_cmp == o_hf_under_fault) begin
                uv_run_ff <= 12'h000;
            end else if (o_hf_under_fault != uv_seen_ff) begin
                uv_run_ff <= 12'h001;
            end else begin
                uv_run_ff <= uv_run_ff + 12'h001;
            end
        end
    end

    a_thr_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !wr_thr |=> $stable(lowfreq_over_threshold_ff))
        else $error("threshold moved without a write");

    a_flt_write_load: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        wr_flt |=> highfreq_fault_filter_ff == $past(i_reg_wdata))
        else $error("filter write lost");

    a_rdata_thr: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == `CHOV_OFS_LF_OVER_THR)
        |=> o_reg_rdata == $past(lowfreq_over_threshold_ff))
        else $error("threshold read wrong");

    a_rdata_flt: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == `CHOV_OFS_HF_FLT)
        |=> o_reg_rdata == $past(highfreq_fault_filter_ff))
        else $error("filter read wrong");

    a_ov_table: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ov_limit == ov_ref_lim)
        else $error("ov debounce cycles off table");

    a_uv_table: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        uv_limit == uv_ref_lim)
        else $error("uv debounce cycles off table");

    a_ov_not_early: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $changed(o_hf_over_fault) |-> $past(ov_run_ff) + 12'h001 >= $past(ov_ref_lim))
        else $error("ov fault moved early");

    a_uv_not_early: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $changed(o_hf_under_fault) |-> $past(uv_run_ff) + 12'h001 >= $past(uv_ref_lim))
        else $error("uv fault moved early");

    a_ov_on_time: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_hf_over_cmp != o_hf_over_fault && o_hf_over_fault == ov_seen_ff
        && ov_run_ff + 12'h001 >= ov_ref_lim) |=> $changed(o_hf_over_fault))
        else $error("ov fault held past its debounce time");

    a_uv_on_time: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_hf_under_cmp != o_hf_under_fault && o_hf_under_fault == uv_seen_ff
        && uv_run_ff + 12'h001 >= uv_ref_lim) |=> $changed(o_hf_under_fault))
        else $error("uv fault held past its debounce time");

endmodule : chov_ch8_regbank

// File: verification/chov_ch8_regbank_bench.sv
`timescale 1ns/1ns
`include "chov_map.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
    $display("FAIL %s expected %0h seen %0h", n, e, s); end end

module chov_ch8_regbank_bench;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_range_scale_select = 1'b0;
    logic [12:0] i_lf_volt_mv = 13'h0000;
    logic i_hf_over_cmp = 1'b0;
    logic i_hf_under_cmp = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_lf_over_fault;
    logic o_hf_over_fault;
    logic o_hf_under_fault;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int cnt_ov = 0;
    int cnt_uv = 0;
    logic rd_d = 1'b0;
    logic lf_chk = 1'b0;
    logic lf_d = 1'b0;
    logic ov_prev = 1'b0;
    logic uv_prev = 1'b0;
    string qn[$];
    logic [11:0] qv[$];

    always #25 i_clock = ~i_clock;

    chov_ch8_regbank dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_range_scale_select(i_range_scale_select),
        .i_lf_volt_mv(i_lf_volt_mv), .i_hf_over_cmp(i_hf_over_cmp),
        .i_hf_under_cmp(i_hf_under_cmp), .o_lf_over_fault(o_lf_over_fault),
        .o_hf_over_fault(o_hf_over_fault), .o_hf_under_fault(o_hf_under_fault));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic expect_val(input string n, input logic [11:0] v);
        qn.push_back(n);
        qv.push_back(v);
    endtask : expect_val

    task automatic check_next(input logic [11:0] s);
        string n;
        logic [11:0] e;
        n = (qn.size() > 0) ? qn.pop_front() : "unexpected";
        e = (qv.size() > 0) ? qv.pop_front() : 'x;
        `CHK(n, e, s)
    endtask : check_next

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
        @(posedge i_clock);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        expect_val("rdata", {4'h0, e});
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        @(posedge i_clock);
    endtask : reg_rd

    task automatic lf_step(input int mv, input logic e);
        expect_val("lf_fault", {11'h000, e});
        i_lf_volt_mv <= 13'(mv);
        lf_chk <= 1'b1;
        @(posedge i_clock);
    endtask : lf_step

    // Glitch one cycle short of the window first, so an early flip shows up
    task automatic deb_edge(input int c, input logic v);
        int n;
        n = (c <= 9) ? (2 << c) : 2048;
        expect_val("over_deb_cycles", 12'(n));
        expect_val("under_deb_cycles", 12'(n));
        i_hf_over_cmp <= v;
        i_hf_under_cmp <= v;
        repeat (n - 1) @(posedge i_clock);
        i_hf_over_cmp <= ~v;
        i_hf_under_cmp <= ~v;
        @(posedge i_clock);
        i_hf_over_cmp <= v;
        i_hf_under_cmp <= v;
        for (int i = 0; i < 2200 && !(o_hf_over_fault === v && o_hf_under_fault === v); i++)
            @(negedge i_clock);
        @(posedge i_clock);
    endtask : deb_edge

    ////////////////////////////////////////////////////////////////////////////////
    // Delayed strobes and differing-cycle counts, sampled as the design samples
    always @(posedge i_clock) begin
        rd_d <= i_reg_rd;
        lf_d <= lf_chk;
        cnt_ov <= (i_hf_over_cmp !== o_hf_over_fault) ? cnt_ov + 1 : 0;
        cnt_uv <= (i_hf_under_cmp !== o_hf_under_fault) ? cnt_uv + 1 : 0;
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            errors++;
            print_verdict();
        end
    end

    // Results are settled by the falling edge, so the watcher samples there
    always @(negedge i_clock) begin
        if (rd_d) check_next({4'h0, o_reg_rdata});
        if (lf_d) check_next({11'h000, o_lf_over_fault});
        if (o_hf_over_fault !== ov_prev) check_next(12'(cnt_ov));
        if (o_hf_under_fault !== uv_prev) check_next(12'(cnt_uv));
        ov_prev = o_hf_over_fault;
        uv_prev = o_hf_under_fault;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] code;
        void'($urandom(32'hEA1DBA89));
        repeat (5) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        reg_rd(`CHOV_OFS_LF_OVER_THR, 8'hFF);
        reg_rd(`CHOV_OFS_HF_FLT, 8'h00);
        $display("test reset_values done");
        code = 8'($urandom);
        reg_wr(`CHOV_OFS_LF_OVER_THR, code);
        reg_wr(8'h00, 8'h5A);
        reg_rd(`CHOV_OFS_LF_OVER_THR, code);
        reg_rd(8'h00, 8'h00);
        reg_wr(`CHOV_OFS_HF_FLT, ~code | 8'h22);
        reg_rd(`CHOV_OFS_HF_FLT, ~code | 8'h22);
        $display("test register_access done");
        for (int s = 0; s < 2; s++) begin
            i_range_scale_select <= s[0];
            lf_step(s ? 800 + 20 * code : 200 + 5 * code, 1'b0);
            lf_step(s ? 801 + 20 * code : 201 + 5 * code, 1'b1);
        end
        lf_chk <= 1'b0;
        // Fixed codes at both scale ends, where an off-by-one step shows most
        reg_wr(`CHOV_OFS_LF_OVER_THR, 8'h01);
        lf_step(820, 1'b0);
        lf_step(821, 1'b1);
        lf_chk <= 1'b0;
        i_range_scale_select <= 1'b0;
        reg_wr(`CHOV_OFS_LF_OVER_THR, 8'hFF);
        lf_step(1475, 1'b0);
        lf_step(1476, 1'b1);
        lf_chk <= 1'b0;
        $display("test lowfreq_threshold done");
        // Reset in mid-run; code zero is tried only as the reset value
        @(posedge i_clock);
        i_rst_b <= 1'b0;
        repeat (5) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        reg_rd(`CHOV_OFS_LF_OVER_THR, 8'hFF);
        reg_rd(`CHOV_OFS_HF_FLT, 8'h00);
        deb_edge(0, 1'b1);
        deb_edge(0, 1'b0);
        for (int c = 2; c < 16; c++) begin
            reg_wr(`CHOV_OFS_HF_FLT, {c[3:0], c[3:0]});
            deb_edge(c, 1'b1);
            deb_edge(c, 1'b0);
        end
        $display("test highfreq_debounce done");
        `CHK("pending_results", 0, qv.size())
        print_verdict();
    end
endmodule : chov_ch8_regbank_bench
